// File: bhl_pkg.sv
package bhl_pkg;
    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_HZ      = 250_000_000;
    localparam int unsigned TICK_MS     = 100;                        // hold resolution
    localparam int unsigned TICK_CYC    = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned DEB_MS      = 10;                         // debounce time
    localparam int unsigned DEB_CYC     = CLK_HZ / 1000 * DEB_MS;
    localparam int unsigned TPS         = 1000 / TICK_MS;             // ticks per second

    // hold brackets in ticks
    localparam logic [9:0] T_REBOOT_LO  = 10'(5 * TPS);
    localparam logic [9:0] T_ACCESS_LO  = 10'(15 * TPS);
    localparam logic [9:0] T_ACCESS_HI  = 10'(18 * TPS);
    localparam logic [9:0] T_FACT_LO    = 10'(30 * TPS);
    localparam logic [9:0] T_FACT_HI    = 10'(33 * TPS);
    localparam logic [9:0] T_HOLD_MAX   = 10'h3ff;

    // blink periods in ticks (full period)
    localparam logic [4:0] P_SLOW       = 5'(10);                     // 1 s slow flash
    localparam logic [4:0] P_FAST       = 5'(4);                      // 0.4 s fast flash
    localparam logic [4:0] P_ALT_FAST   = 5'(3);                      // about 3 per second
    localparam logic [4:0] P_SLEEP      = 5'(30);                     // 3 s sleep flash
    localparam logic [4:0] SLEEP_ON     = 5'(1);                      // sleep flash width

    // ****************************************************************
    // led colour codes {red, green}
    // ****************************************************************
    localparam logic [1:0] LED_OFF      = 2'h0;
    localparam logic [1:0] LED_GREEN    = 2'h1;
    localparam logic [1:0] LED_RED      = 2'h2;
    localparam logic [1:0] LED_YELLOW   = 2'h3;

    // ****************************************************************
    // interrupt status bits
    // ****************************************************************
    localparam int unsigned EV_REBOOT   = 0;
    localparam int unsigned EV_ACCESS   = 1;
    localparam int unsigned EV_FACTORY  = 2;
    localparam int unsigned EV_PURGE    = 3;
    localparam int unsigned EV_NONE     = 4;
    localparam int unsigned EV_W        = 5;

    // ****************************************************************
    // register map (word offsets on the plain port)
    // ****************************************************************
    localparam logic [3:0] A_STATUS     = 4'h0;                       // r: sticky events, w1c
    localparam logic [3:0] A_MASK       = 4'h1;                       // rw
    localparam logic [3:0] A_FLAGS      = 4'h2;                       // rw: firmware flags
    localparam logic [3:0] A_HOLD       = 4'h3;                       // r: live hold ticks
    localparam logic [4:0] MASK_RST     = 5'h00;
    localparam logic [9:0] FLAGS_RST    = 10'h000;

    // firmware flag bit positions
    localparam int unsigned F_OS_OK     = 0;
    localparam int unsigned F_ALARM     = 1;
    localparam int unsigned F_EMERG     = 2;
    localparam int unsigned F_LOCKOUT   = 3;
    localparam int unsigned F_DISC      = 4;
    localparam int unsigned F_DONE      = 5;
    localparam int unsigned F_GPS_FIT   = 6;
    localparam int unsigned F_SAVE      = 7;
    localparam int unsigned F_SLEEP     = 8;
    localparam int unsigned F_PWR_OK    = 9;
    localparam int unsigned FLAGS_W     = 10;

    // hold phases
    typedef enum logic [4:0] {
        PH_IDLE   = 5'h01,
        PH_DARK   = 5'h02,
        PH_REBOOT = 5'h04,
        PH_ACCESS = 5'h08,
        PH_FACT   = 5'h10
    } bhl_phase_t;
endpackage

// File: bhl_blink.sv
`timescale 1ns/100ps
`default_nettype none
// ********************************************************************
// free running blink phase counter on the shared tick
// ********************************************************************
module bhl_blink #(
    parameter logic [4:0] PERIOD = 5'(10),
    parameter logic [4:0] ON_LEN = 5'(5)
) (
    input  wire logic clk,     // system clock
    input  wire logic arst_n,  // async reset, low
    input  wire logic tick,    // prescaled tick
    output logic      lit      // high during on part
);
    logic [4:0] cnt_ff;

    // wraps at the period; on part is the first ON_LEN ticks
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_ff <= 5'h00;
        end else if (tick) begin
            cnt_ff <= (cnt_ff >= PERIOD - 5'h01) ? 5'h00 : cnt_ff + 5'h01;
        end
    end

    assign lit = (cnt_ff < ON_LEN);
endmodule
`default_nettype wire

// File: bhl_panel.sv
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module bhl_panel #(
    parameter int unsigned TICK_CYC = bhl_pkg::TICK_CYC,
    parameter int unsigned DEB_CYC  = bhl_pkg::DEB_CYC
) (
    input  wire logic        clk,          // 250 MHz system clock
    input  wire logic        arst_n,       // async reset, low
    input  wire logic        button_n,     // reset button pin, low when pressed
    input  wire logic        tx_active,    // transmitter sending
    input  wire logic        gps_sync,     // timing module synchronised
    input  wire logic        rx_lock,      // receiver locked to a packet
    input  wire logic        rx_strong,    // channel above -80 dBm
    input  wire logic [3:0]  reg_addr,     // register word address
    input  wire logic [31:0] reg_wdata,    // write data
    input  wire logic        reg_wr,       // write strobe
    input  wire logic        reg_rd,       // read strobe
    output logic      [31:0] reg_rdata,    // read data, cycle after strobe
    output logic             irq,          // level interrupt
    output logic             do_reboot,    // pulse: reboot
    output logic             do_access,    // pulse: restore access defaults
    output logic             do_factory,   // pulse: restore factory settings
    output logic             do_purge,     // pulse: full erase
    output logic      [1:0]  status_led,   // {red, green}
    output logic      [1:0]  tx_led,       // {red, green}
    output logic      [1:0]  rx_led,       // {red, green}
    output logic             power_led     // green
);
    // ****************************************************************
    // prescaler
    // ****************************************************************
    logic [31:0] pre_ff;
    logic        tick;

    // one tick per hold resolution step
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pre_ff <= 32'h0;
        end else begin
            pre_ff <= (pre_ff == TICK_CYC - 1) ? 32'h0 : pre_ff + 32'h1;
        end
    end
    assign tick = (pre_ff == TICK_CYC - 1);

    // ****************************************************************
    // button synchroniser and debounce
    // ****************************************************************
    logic        sync1_ff;
    logic        sync2_ff;
    logic        press_ff;
    logic [31:0] deb_ff;

    // two flops before anything looks at the pin
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1_ff <= 1'b0;
            sync2_ff <= 1'b0;
        end else begin
            sync1_ff <= ~button_n;
            sync2_ff <= sync1_ff;
        end
    end

    // a change must stand for the debounce time; contact bounce restarts it
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            press_ff <= 1'b0;
            deb_ff   <= 32'h0;
        end else if (sync2_ff == press_ff) begin
            deb_ff <= 32'h0;
        end else if (deb_ff == DEB_CYC - 1) begin
            press_ff <= sync2_ff;
            deb_ff   <= 32'h0;
        end else begin
            deb_ff <= deb_ff + 32'h1;
        end
    end

    // ****************************************************************
    // hold timer and phase
    // ****************************************************************
    logic [9:0]          hold_ff;
    logic                press_d_ff;
    logic                release_ev;
    bhl_pkg::bhl_phase_t phase;
    logic [9:0]          flags_ff;
    logic                lockout;

    assign lockout    = flags_ff[bhl_pkg::F_LOCKOUT];
    assign release_ev = press_d_ff & ~press_ff;

    // counts ticks while held; saturates so a very long hold stays out of range
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            hold_ff    <= 10'h000;
            press_d_ff <= 1'b0;
        end else begin
            press_d_ff <= press_ff;
            if (!press_ff) begin
                hold_ff <= 10'h000;
            end else if (tick && hold_ff != bhl_pkg::T_HOLD_MAX) begin
                hold_ff <= hold_ff + 10'h001;
            end
        end
    end

    // bracket decode, used for both the led and the release action
    function automatic bhl_pkg::bhl_phase_t bracket(input logic [9:0] t,
                                                    input logic       lock);
        if (t < bhl_pkg::T_REBOOT_LO) begin
            return bhl_pkg::PH_DARK;
        end else if (t < bhl_pkg::T_ACCESS_LO) begin
            return bhl_pkg::PH_REBOOT;
        end else if (t < bhl_pkg::T_ACCESS_HI) begin
            return bhl_pkg::PH_ACCESS;
        end else if (!lock && t >= bhl_pkg::T_FACT_LO && t < bhl_pkg::T_FACT_HI) begin
            return bhl_pkg::PH_FACT;
        end else begin
            return bhl_pkg::PH_IDLE;
        end
    endfunction

    // the phase while released is idle; while held, the bracket reached
    always_comb begin
        phase = bhl_pkg::PH_IDLE;
        if (press_ff) begin
            phase = bracket(hold_ff, lockout);
        end
    end

    // ****************************************************************
    // release actions
    // ****************************************************************
    bhl_pkg::bhl_phase_t rel_ph;
    assign rel_ph = bracket(hold_ff, lockout);

    // one pulse on release, chosen from the bracket the hold ended in
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            do_reboot  <= 1'b0;
            do_access  <= 1'b0;
            do_factory <= 1'b0;
            do_purge   <= 1'b0;
        end else begin
            do_reboot  <= 1'b0;
            do_access  <= 1'b0;
            do_factory <= 1'b0;
            do_purge   <= 1'b0;
            if (release_ev) begin
                case (rel_ph)
                    bhl_pkg::PH_REBOOT: do_reboot  <= 1'b1;
                    bhl_pkg::PH_ACCESS: begin
                        do_access <= ~lockout;
                        do_purge  <= lockout;
                    end
                    bhl_pkg::PH_FACT:   do_factory <= 1'b1;
                    default:            ;
                endcase
            end
        end
    end

    // ****************************************************************
    // blink sources
    // ****************************************************************
    logic bl_slow;
    logic bl_fast;
    logic bl_alt;
    logic bl_sleep;

    bhl_blink #(.PERIOD(bhl_pkg::P_SLOW), .ON_LEN(bhl_pkg::P_SLOW >> 1)) u_slow (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick),
        .lit    (bl_slow)
    );
    bhl_blink #(.PERIOD(bhl_pkg::P_FAST), .ON_LEN(bhl_pkg::P_FAST >> 1)) u_fast (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick),
        .lit    (bl_fast)
    );
    // odd period: about three swaps per second is all that is needed
    bhl_blink #(.PERIOD(bhl_pkg::P_ALT_FAST), .ON_LEN(5'(1))) u_alt (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick),
        .lit    (bl_alt)
    );
    bhl_blink #(.PERIOD(bhl_pkg::P_SLEEP), .ON_LEN(bhl_pkg::SLEEP_ON)) u_sleep (
        .clk    (clk),
        .arst_n (arst_n),
        .tick   (tick),
        .lit    (bl_sleep)
    );

    // ****************************************************************
    // led drivers
    // ****************************************************************
    logic [1:0] nxt_status;
    logic [1:0] nxt_tx;
    logic [1:0] nxt_rx;
    logic       nxt_power;

    // status priority: button, emergency, disc, alarm, running
    always_comb begin
        nxt_status = bhl_pkg::LED_OFF;
        case (phase)
            bhl_pkg::PH_DARK:   nxt_status = bhl_pkg::LED_OFF;
            bhl_pkg::PH_REBOOT: nxt_status = bl_slow ? bhl_pkg::LED_GREEN
                                                     : bhl_pkg::LED_OFF;
            bhl_pkg::PH_ACCESS: nxt_status = bl_fast ? bhl_pkg::LED_GREEN
                                                     : bhl_pkg::LED_OFF;
            bhl_pkg::PH_FACT:   nxt_status = bl_fast ? bhl_pkg::LED_RED
                                                     : bhl_pkg::LED_OFF;
            default: begin
                if (press_ff) begin
                    nxt_status = bhl_pkg::LED_OFF;
                end else if (flags_ff[bhl_pkg::F_EMERG]) begin
                    nxt_status = bl_fast ? bhl_pkg::LED_RED : bhl_pkg::LED_OFF;
                end else if (flags_ff[bhl_pkg::F_DISC] && flags_ff[bhl_pkg::F_DONE]) begin
                    nxt_status = bl_alt ? bhl_pkg::LED_RED : bhl_pkg::LED_GREEN;
                end else if (flags_ff[bhl_pkg::F_DISC]) begin
                    nxt_status = bl_slow ? bhl_pkg::LED_RED : bhl_pkg::LED_GREEN;
                end else if (flags_ff[bhl_pkg::F_ALARM]) begin
                    nxt_status = bhl_pkg::LED_RED;
                end else if (flags_ff[bhl_pkg::F_OS_OK]) begin
                    nxt_status = bhl_pkg::LED_GREEN;
                end
            end
        endcase
    end

    // radio leds: transmit beats the timing blink, lock beats strong signal
    always_comb begin
        nxt_tx = bhl_pkg::LED_OFF;
        if (tx_active) begin
            nxt_tx = bhl_pkg::LED_RED;
        end else if (flags_ff[bhl_pkg::F_GPS_FIT] && gps_sync && bl_slow) begin
            nxt_tx = bhl_pkg::LED_GREEN;
        end
        nxt_rx = bhl_pkg::LED_OFF;
        if (rx_lock) begin
            nxt_rx = bhl_pkg::LED_GREEN;
        end else if (rx_strong) begin
            nxt_rx = bhl_pkg::LED_YELLOW;
        end
        nxt_power = 1'b0;
        if (flags_ff[bhl_pkg::F_SLEEP]) begin
            nxt_power = bl_sleep;
        end else if (flags_ff[bhl_pkg::F_SAVE]) begin
            nxt_power = bl_slow;
        end else begin
            nxt_power = flags_ff[bhl_pkg::F_PWR_OK];
        end
    end

    // registered so the pins never glitch
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            status_led <= bhl_pkg::LED_OFF;
            tx_led     <= bhl_pkg::LED_OFF;
            rx_led     <= bhl_pkg::LED_OFF;
            power_led  <= 1'b0;
        end else begin
            status_led <= nxt_status;
            tx_led     <= nxt_tx;
            rx_led     <= nxt_rx;
            power_led  <= nxt_power;
        end
    end

    // ****************************************************************
    // registers and interrupt
    // ****************************************************************
    logic [4:0] stat_ff;
    logic [4:0] mask_ff;
    logic [4:0] ev;

    assign ev[bhl_pkg::EV_REBOOT]  = do_reboot;
    assign ev[bhl_pkg::EV_ACCESS]  = do_access;
    assign ev[bhl_pkg::EV_FACTORY] = do_factory;
    assign ev[bhl_pkg::EV_PURGE]   = do_purge;
    assign ev[bhl_pkg::EV_NONE]    = release_ev & (rel_ph == bhl_pkg::PH_IDLE
                                                   || rel_ph == bhl_pkg::PH_DARK);

    // sticky status: a new event wins over a write-one-to-clear
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            stat_ff <= 5'h00;
        end else begin
            stat_ff <= (stat_ff & ~((reg_wr && reg_addr == bhl_pkg::A_STATUS)
                                    ? reg_wdata[4:0] : 5'h00)) | ev;
        end
    end

    // software written mask and firmware flags
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_ff  <= bhl_pkg::MASK_RST;
            flags_ff <= bhl_pkg::FLAGS_RST;
        end else if (reg_wr) begin
            if (reg_addr == bhl_pkg::A_MASK) begin
                mask_ff <= reg_wdata[4:0];
            end
            if (reg_addr == bhl_pkg::A_FLAGS) begin
                flags_ff <= reg_wdata[9:0];
            end
        end
    end

    // read data stands only in the cycle after the strobe; unmapped reads zero
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= 32'h0;
        end else if (reg_rd) begin
            case (reg_addr)
                bhl_pkg::A_STATUS: reg_rdata <= {27'h0, stat_ff};
                bhl_pkg::A_MASK:   reg_rdata <= {27'h0, mask_ff};
                bhl_pkg::A_FLAGS:  reg_rdata <= {22'h0, flags_ff};
                bhl_pkg::A_HOLD:   reg_rdata <= {21'h0, press_ff, hold_ff};
                default:           reg_rdata <= 32'h0;
            endcase
        end else begin
            reg_rdata <= 32'h0;
        end
    end

    assign irq = |(stat_ff & mask_ff);
endmodule
`default_nettype wire

// File: bhl_panel_checker.sv
`timescale 1ns/100ps
`default_nettype none
module bhl_panel_checker #(
    parameter int unsigned TICK_CYC = 10,
    parameter int unsigned DEB_CYC  = 3
) (
    input wire logic       clk,        // clock
    input wire logic       arst_n,     // reset, low
    input wire logic       button_n,   // button pin
    input wire logic       tx_active,  // sending
    input wire logic       gps_sync,   // timing synced
    input wire logic       rx_lock,    // packet lock
    input wire logic       rx_strong,  // strong signal
    input wire logic       do_reboot,  // reboot pulse
    input wire logic       do_access,  // access pulse
    input wire logic       do_factory, // factory pulse
    input wire logic       do_purge,   // erase pulse
    input wire logic [1:0] status_led, // status colour
    input wire logic [1:0] tx_led,     // tx colour
    input wire logic [1:0] rx_led      // rx colour
);
    // ****************************************************************
    // press length bookkeeping
    // ****************************************************************
    int unsigned low_ff;  // cycles of current press
    int unsigned last_ff; // cycles of last press
    logic [1:0]  up_ff;   // outputs settled after reset
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    // a bounce restarts the count; bracket bounds below allow one tick of prescaler phase
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            low_ff <= 0;
            last_ff <= 0;
            up_ff <= 2'h0;
        end else begin
            low_ff <= button_n ? 0 : low_ff + 1;
            last_ff <= (button_n && low_ff != 0) ? low_ff : last_ff;
            up_ff <= {up_ff[0], 1'b1};
        end
    end
    property p_one_act; $onehot0({do_reboot, do_access, do_factory, do_purge}); endproperty
    a_one_act: assert property (p_one_act) else $error("two actions at once");
    property p_rel; (do_reboot || do_access || do_factory || do_purge) |-> button_n && $past(button_n) && $past(button_n, 2); endproperty
    a_rel: assert property (p_rel) else $error("action while held");
    property p_rb; do_reboot |-> last_ff >= 49 * TICK_CYC && last_ff <= 151 * TICK_CYC; endproperty
    a_rb: assert property (p_rb) else $error("reboot outside bracket");
    property p_ac; (do_access || do_purge) |-> last_ff >= 149 * TICK_CYC && last_ff <= 181 * TICK_CYC; endproperty
    a_ac: assert property (p_ac) else $error("access or erase outside bracket");
    property p_fa; do_factory |-> last_ff >= 299 * TICK_CYC && last_ff <= 331 * TICK_CYC; endproperty
    a_fa: assert property (p_fa) else $error("factory outside bracket");
    property p_dark; !button_n && low_ff > DEB_CYC + 6 && low_ff < 49 * TICK_CYC |-> status_led == bhl_pkg::LED_OFF; endproperty
    a_dark: assert property (p_dark) else $error("status lit early in press");
    property p_tx; up_ff[1] && (tx_active || !gps_sync) |=> tx_led == ($past(tx_active) ? bhl_pkg::LED_RED : bhl_pkg::LED_OFF); endproperty
    a_tx: assert property (p_tx) else $error("tx colour wrong");
    property p_rx; up_ff[1] |=> rx_led == ($past(rx_lock) ? bhl_pkg::LED_GREEN : $past(rx_strong) ? bhl_pkg::LED_YELLOW : bhl_pkg::LED_OFF); endproperty
    a_rx: assert property (p_rx) else $error("rx colour wrong");
    c_fa: cover property (do_factory);
    c_pu: cover property (do_purge);
    c_dk: cover property (!button_n && status_led == bhl_pkg::LED_OFF);
endmodule
bind bhl_panel bhl_panel_checker #(.TICK_CYC(TICK_CYC), .DEB_CYC(DEB_CYC)) u_chk (
    .clk(clk), .arst_n(arst_n), .button_n(button_n), .tx_active(tx_active),
    .gps_sync(gps_sync), .rx_lock(rx_lock), .rx_strong(rx_strong), .do_reboot(do_reboot),
    .do_access(do_access), .do_factory(do_factory), .do_purge(do_purge),
    .status_led(status_led), .tx_led(tx_led), .rx_led(rx_led));
`default_nettype wire

// File: bhl_operator.sv
`timescale 1ns/100ps
`default_nettype none
module bhl_operator (
    input  wire logic clk,     // system clock
    output logic      button_n // contact, low while pressed
);
    // ****************************************************************
    // person at the button
    // ****************************************************************
    initial button_n = 1'b1;
    // a one-cycle bounce first, which the debounce must swallow
    task automatic hold(input int unsigned cyc);
        @(posedge clk);
        button_n <= 1'b0;
        @(posedge clk);
        button_n <= 1'b1;
        @(posedge clk);
        button_n <= 1'b0;
        repeat (cyc) @(posedge clk);
        button_n <= 1'b1;
    endtask
endmodule
`default_nettype wire

// File: tb_button_hold_led_indicator.sv
`timescale 1ns/100ps
`default_nettype none
module tb_button_hold_led_indicator;
    // ****************************************************************
    // bench
    // ****************************************************************
    localparam int unsigned TC = 10;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [3:0]  side = 4'h0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [3:0]  act;
    logic        irq;
    logic        power_led;
    logic [1:0]  status_led;
    logic [1:0]  tx_led;
    logic [1:0]  rx_led;
    logic [3:0]  seen_ff = 4'h0;
    logic        seen_clr = 1'b0;
    wire logic   button_n;
    int          bad_count = 0;
    int          n_tests = 0;
    int          lo_t [6] = '{5, 53, 153, 183, 303, 333};
    int          hi_t [6] = '{45, 147, 177, 297, 327, 360};
    logic [9:0]  fl [5] = '{10'h243, 10'h206, 10'h090, 10'h130, 10'h001};
    logic [5:0]  ex [5] = '{6'h24, 6'h25, 6'h36, 6'h36, 6'h12};
    bhl_operator op (.clk(clk), .button_n(button_n));
    bhl_panel #(.TICK_CYC(TC), .DEB_CYC(3)) u_bhl_panel (
        .clk(clk), .arst_n(arst_n), .button_n(button_n), .tx_active(side[0]),
        .gps_sync(side[1]), .rx_lock(side[2]), .rx_strong(side[3]), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq(irq), .do_reboot(act[0]), .do_access(act[1]), .do_factory(act[2]),
        .do_purge(act[3]), .status_led(status_led), .tx_led(tx_led), .rx_led(rx_led),
        .power_led(power_led));
    always #2 clk = ~clk;
    // action pulses last one cycle, so they are latched for the main sequence
    always @(posedge clk) seen_ff <= seen_clr ? 4'h0 : seen_ff | act;
    // every cycle stepped by tick_n also stirs the radio side levels
    task automatic tick_n(input int n);
        repeat (n) begin
            @(posedge clk);
            side <= 4'($urandom);
        end
    endtask
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        if (bad_count == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        tick_n(1);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        tick_n(1);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        tick_n(1);
        reg_rd <= 1'b1;
        reg_addr <= a;
        tick_n(1);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    // reference: event index from hold ticks and lockout
    function automatic int exp_ev(input int t, input int lk);
        if (t >= 50 && t < 150) return 0;
        if (t >= 150 && t < 180) return lk ? 3 : 1;
        if (t >= 300 && t < 330 && lk == 0) return 2;
        return 4;
    endfunction
    // presses in every bracket under both lockout settings, then the led table
    initial begin
        logic [31:0] d;
        logic [5:0]  s;
        logic [3:0]  p;
        int          t;
        int          ev;
        int          m;
        void'($urandom(32'h44870028));
        tick_n(3);
        arst_n <= 1'b1;
        rd(bhl_pkg::A_MASK, d);
        chk("mask reset", d, 32'(bhl_pkg::MASK_RST));
        rd(4'hf, d);
        chk("unmapped", d, 32'h0);
        rd(bhl_pkg::A_HOLD, d);
        chk("hold idle", d, 32'h0);
        for (int i = 0; i < 12; i++) begin
            t = $urandom_range(hi_t[i / 2], lo_t[i / 2]);
            m = $urandom_range(31, 0);
            wr(bhl_pkg::A_FLAGS, (i % 2) ? 32'h209 : 32'h201);
            wr(bhl_pkg::A_MASK, 32'(m));
            seen_clr <= 1'b1;
            tick_n(1);
            seen_clr <= 1'b0;
            op.hold(t * TC);
            ev = exp_ev(t, i % 2);
            d = 32'h0;
            for (int k = 0; k < 40 && d == 0; k++)
                rd(bhl_pkg::A_STATUS, d);
            if (d == 0) begin
                bad_count++;
                results();
            end
            chk("status", d, 32'h1 << ev);
            chk("action", {28'h0, seen_ff}, 32'((1 << ev) & 15));
            chk("irq", {31'h0, irq}, {31'h0, m[ev]});
            chk("status_led", {30'h0, status_led}, 32'(bhl_pkg::LED_GREEN));
            wr(bhl_pkg::A_STATUS, 32'h1 << ev);
            rd(bhl_pkg::A_STATUS, d);
            chk("status clear", d | {31'h0, irq}, 32'h0);
        end
        for (int j = 0; j < 5; j++) begin
            wr(bhl_pkg::A_FLAGS, 32'(fl[j]));
            rd(bhl_pkg::A_FLAGS, d);
            chk("flags", d, 32'(fl[j]));
            s = 6'h0;
            repeat (400) begin
                p = side;
                tick_n(1);
                #1 s[status_led] = 1'b1;
                s[4 + power_led] = 1'b1;
                chk("rx_led", {30'h0, rx_led}, p[2] ? 32'(bhl_pkg::LED_GREEN)
                    : p[3] ? 32'(bhl_pkg::LED_YELLOW) : 32'h0);
                chk("tx_led", {30'h0, tx_led}, p[0] ? 32'(bhl_pkg::LED_RED)
                    : (fl[j][6] && p[1]) ? {31'h0, tx_led[0]} : 32'h0);
            end
            chk("leds", {26'h0, s}, 32'(ex[j]));
        end
        results();
    end
endmodule
`default_nettype wire
